// ### logic/slcd_scan_ctrl.sv
// Segment LCD scan controller with registers and display memory
`timescale 1ns/10ps
module slcd_scan_ctrl
  import slcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic bus_hit,
  input wire logic sub_clock_one,
  input wire logic [slcd_pkg::SLCD_NSHARED-1:0] port_dir_out,
  input wire logic [slcd_pkg::SLCD_NSHARED-1:0] port_latch,
  input wire logic [slcd_pkg::SLCD_NSHARED-1:0] port_pullup,
  output logic [slcd_pkg::SLCD_NSEG-1:0] seg_out,
  output logic [slcd_pkg::SLCD_NSEG-1:0] seg_oe,
  output logic [slcd_pkg::SLCD_NSHARED-1:0] pin_pullup_en,
  output logic [slcd_pkg::SLCD_NCOM-1:0] com_out,
  output logic [slcd_pkg::SLCD_NCOM-1:0] com_sel,
  output logic drive_power_on,
  output logic drive_volt_pin_a_oe,
  output logic drive_volt_pin_b_oe,
  output logic panel_scan_clock
);
  import slcd_pkg::*;

  // Configuration registers and their next values
  logic [7:0] mode_reg, mode_next;
  logic [7:0] frame_reg, frame_next;
  logic [7:0] pf7_reg, pf7_next;
  logic [7:0] pf8_reg, pf8_next;
  logic [7:0] pf9_reg, pf9_next;
  logic [7:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  // Display memory, three cells per segment
  logic [2:0] dmem [SLCD_NSEG];
  // Sub clock synchroniser and scan timing state
  logic sub_s1_reg, sub_s2_reg, sub_s3_reg;
  logic sub_rise;
  logic [SLCD_DIVW-1:0] div_reg, div_next;
  slcd_slot_e slot_reg, slot_next;
  logic polar_reg, polar_next;
  logic tick;
  logic [15:0] mem_off;
  logic mem_sel;
  // Next values of the registered pin outputs
  logic [SLCD_NSEG-1:0] seg_next, segoe_next;
  logic [SLCD_NCOM-1:0] com_next, comsel_next;
  logic [SLCD_NSHARED-1:0] pullup_next;
  logic pwr_next;
  logic sclk_next;
  logic [SLCD_NSHARED-1:0] pf_all;
  logic [2:0] dmode;
  logic disp_on, active;

  // Mode fields and the shared-pin function bits in pin order
  assign dmode = mode_reg[2:0];
  assign disp_on = mode_reg[SLCD_BIT_ON];
  assign pf_all = {pf9_reg[5:0], pf8_reg, pf7_reg};
  // Display window is one range compare; offset indexes the array
  assign mem_off = bus_addr - SLCD_MEM_BASE;
  assign mem_sel = (bus_addr >= SLCD_MEM_BASE) && (bus_addr <= SLCD_MEM_LAST);

  // Register writes and registered read data
  always_comb
  begin
    mode_next = mode_reg;
    frame_next = frame_reg;
    pf7_next = pf7_reg;
    pf8_next = pf8_reg;
    pf9_next = pf9_reg;
    rdata_next = 8'h00;
    hit_next = 1'b0;
    // Reserved bits masked on write, so they always read zero
    if (bus_wr)
    begin
      case (bus_addr)
        SLCD_ADDR_MODE: mode_next = bus_wdata & SLCD_MODE_MASK;
        SLCD_ADDR_FRAME: frame_next = bus_wdata & SLCD_FRAME_MASK;
        SLCD_ADDR_PF7: pf7_next = bus_wdata;
        SLCD_ADDR_PF8: pf8_next = bus_wdata;
        SLCD_ADDR_PF9: pf9_next = bus_wdata & SLCD_PF9_MASK;
        default: mode_next = mode_reg;
      endcase
    end
    // Reads show the value from before a same-cycle write
    if (bus_rd || bus_wr)
    begin
      hit_next = 1'b1;
      case (bus_addr)
        SLCD_ADDR_MODE: rdata_next = mode_reg;
        SLCD_ADDR_FRAME: rdata_next = frame_reg;
        SLCD_ADDR_PF7: rdata_next = pf7_reg;
        SLCD_ADDR_PF8: rdata_next = pf8_reg;
        SLCD_ADDR_PF9: rdata_next = pf9_reg;
        default:
        begin
          // Upper bits of display bytes have no cells and read zero
          hit_next = mem_sel;
          rdata_next = mem_sel ? {5'h00, dmem[mem_off[4:0]]} : 8'h00;
        end
      endcase
    end
  end

  // Control registers; all clear on reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Every register clears, so the display starts dark
      mode_reg <= SLCD_RESET_VAL;
      frame_reg <= SLCD_RESET_VAL;
      pf7_reg <= SLCD_RESET_VAL;
      pf8_reg <= SLCD_RESET_VAL;
      pf9_reg <= SLCD_RESET_VAL;
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
    end
    else
    begin
      // Writes land on the edge that samples the strobe
      mode_reg <= mode_next;
      frame_reg <= frame_next;
      pf7_reg <= pf7_next;
      pf8_reg <= pf8_next;
      pf9_reg <= pf9_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  // Display memory, three cells per segment; no reset, like RAM
  // Writes outside the window never reach the array
  always_ff @(posedge core_clk)
  begin
    if (bus_wr && mem_sel)
      dmem[mem_off[4:0]] <= bus_wdata[2:0] & SLCD_DMEM_MASK[2:0];
  end

  // Sub clock is asynchronous: two stages before any logic
  // Sub clock sync; edge found on the second and third stages only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_s1_reg <= 1'b0;
      sub_s2_reg <= 1'b0;
      sub_s3_reg <= 1'b0;
    end
    else
    begin
      sub_s1_reg <= sub_clock_one;
      sub_s2_reg <= sub_s1_reg;
      sub_s3_reg <= sub_s2_reg;
    end
  end

  // Edge taken from stages two and three, never from stage one
  assign sub_rise = sub_s2_reg && !sub_s3_reg;

  // A frame select change is only safe with the display off
  // Frame divider counts sub clock rising edges
  always_comb
  begin
    tick = 1'b0;
    div_next = div_reg;
    slot_next = slot_reg;
    polar_next = polar_reg;
    if (!active)
    begin
      // Restart scan cleanly at the next enable
      div_next = '0;
      slot_next = SLCD_SLOT0;
      polar_next = 1'b0;
    end
    else if (sub_rise)
    begin
      div_next = div_reg + 1'b1;
      // Frame end at 2^(6+sel) sub clock periods
      if (div_next[SLCD_DIV_BASE + frame_reg[1:0]])
      begin
        tick = 1'b1;
        div_next = '0;
      end
    end
    if (tick)
    begin
      // Three-division walks the commons; static stays in slot 0
      case (slot_reg)
        SLCD_SLOT0: slot_next = (dmode == SLCD_DMODE_TRI) ? SLCD_SLOT1
                                                          : SLCD_SLOT0;
        SLCD_SLOT1: slot_next = SLCD_SLOT2;
        default: slot_next = SLCD_SLOT0;
      endcase
      // One flip per full frame of all slots
      if (dmode == SLCD_DMODE_STATIC || slot_reg == SLCD_SLOT2)
        polar_next = !polar_reg;
    end
  end

  // Scan only with display on and a legal mode selected
  assign active = disp_on && (dmode == SLCD_DMODE_TRI ||
                              dmode == SLCD_DMODE_STATIC);

  // Scan state registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg <= '0;
      slot_reg <= SLCD_SLOT0;
      polar_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      slot_reg <= slot_next;
      polar_reg <= polar_next;
    end
  end

  // Common select and level: polarity flips, so DC averages out
  always_comb
  begin
    comsel_next = '0;
    com_next = '0;
    if (active)
    begin
      // Static drives all three alike; tri walks one at a time
      if (dmode == SLCD_DMODE_STATIC)
        comsel_next = '1;
      else
        comsel_next = 3'b001 << slot_reg;
      com_next = comsel_next & {SLCD_NCOM{polar_reg}};
    end
  end

  // Segment drive per pin; shared pins follow port logic in port mode
  genvar g;
  generate
    for (g = 0; g < SLCD_NSEG; g++)
    begin : g_seg
      logic segbit;
      logic scan_lvl;
      // Static reads bit 0 only, leaving bits 1 and 2 as storage
      assign segbit = dmem[g][(dmode == SLCD_DMODE_STATIC) ? 2'd0
                                                        : slot_reg];
      // Held low unless scanning, whatever the memory holds
      assign scan_lvl = active && (segbit ^ polar_reg);
      if (g < SLCD_NDEDIC)
      begin : g_ded
        // Dedicated pins always drive the glass
        assign segoe_next[g] = 1'b1;
        assign seg_next[g] = scan_lvl;
      end
      else
      begin : g_shr
        // Function bit picks segment or port use
        logic lcd_pin;
        assign lcd_pin = pf_all[g - SLCD_NDEDIC];
        // Port direction and latch ignored in segment mode
        assign segoe_next[g] = lcd_pin
                               || port_dir_out[g - SLCD_NDEDIC];
        assign seg_next[g] = lcd_pin ? scan_lvl
                                     : port_latch[g - SLCD_NDEDIC];
      end
    end
  endgenerate

  // Pull-up control passes through; segment mode never cuts it
  always_comb
  begin
    pullup_next = port_pullup;
    // Both drive pins float together with the supply off
    pwr_next = mode_reg[SLCD_BIT_PWR];
    sclk_next = polar_reg;
  end

  // Output flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Dark glass and supply off while in reset
      seg_out <= '0;
      seg_oe <= '0;
      com_out <= '0;
      com_sel <= '0;
      pin_pullup_en <= '0;
      drive_power_on <= 1'b0;
      drive_volt_pin_a_oe <= 1'b0;
      drive_volt_pin_b_oe <= 1'b0;
      panel_scan_clock <= 1'b0;
    end
    else
    begin
      // Commons and segments change on the same edge
      seg_out <= seg_next;
      seg_oe <= segoe_next;
      com_out <= com_next;
      com_sel <= comsel_next;
      pin_pullup_en <= pullup_next;
      drive_power_on <= pwr_next;
      drive_volt_pin_a_oe <= pwr_next;
      drive_volt_pin_b_oe <= pwr_next;
      panel_scan_clock <= sclk_next;
    end
  end

  // Bus read port straight from its flops
  assign bus_rdata = rdata_reg;
  assign bus_hit = hit_reg;
endmodule : slcd_scan_ctrl

// ### logic/slcd_pkg.sv
// Package of constants for the segment LCD scan controller
package slcd_pkg;
  // Register byte addresses
  localparam logic [15:0] SLCD_ADDR_PF7 = 16'hFF57;
  localparam logic [15:0] SLCD_ADDR_PF8 = 16'hFF58;
  localparam logic [15:0] SLCD_ADDR_PF9 = 16'hFF59;
  localparam logic [15:0] SLCD_ADDR_MODE = 16'hFF90;
  localparam logic [15:0] SLCD_ADDR_FRAME = 16'hFF91;
  // Display memory window
  localparam logic [15:0] SLCD_MEM_BASE = 16'hFA00;
  localparam logic [15:0] SLCD_MEM_LAST = 16'hFA1D;
  localparam int SLCD_NSEG = 30;
  localparam int SLCD_NSHARED = 22;
  localparam int SLCD_NDEDIC = 8;
  localparam int SLCD_NCOM = 3;
  localparam logic [7:0] SLCD_RESET_VAL = 8'h00;
  // Mode register fields
  localparam int SLCD_BIT_ON = 7;
  localparam int SLCD_BIT_PWR = 4;
  localparam logic [7:0] SLCD_MODE_MASK = 8'h97;
  localparam logic [7:0] SLCD_FRAME_MASK = 8'h03;
  localparam logic [7:0] SLCD_PF9_MASK = 8'h3F;
  localparam logic [7:0] SLCD_DMEM_MASK = 8'h07;
  localparam logic [2:0] SLCD_DMODE_NONE = 3'h0;
  localparam logic [2:0] SLCD_DMODE_TRI = 3'h1;
  localparam logic [2:0] SLCD_DMODE_STATIC = 3'h4;
  // Frame divider: 2^6 .. 2^9 sub-clock periods per frame
  localparam int SLCD_DIV_BASE = 6;
  localparam int SLCD_DIVW = 10;
  // Scan slot state
  typedef enum logic [1:0] {
    SLCD_SLOT0 = 2'b00,
    SLCD_SLOT1 = 2'b01,
    SLCD_SLOT2 = 2'b10
  } slcd_slot_e;
endpackage : slcd_pkg

// ### bench/slcd_scan_ctrl_props.sv
// Port checker for the segment LCD scan controller
`timescale 1ns/10ps
module slcd_scan_ctrl_props
  import slcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_hit,
  input wire logic [SLCD_NSHARED-1:0] port_pullup,
  input wire logic [SLCD_NSEG-1:0] seg_out,
  input wire logic [SLCD_NSHARED-1:0] pin_pullup_en,
  input wire logic [SLCD_NCOM-1:0] com_out,
  input wire logic [SLCD_NCOM-1:0] com_sel,
  input wire logic drive_power_on,
  input wire logic drive_volt_pin_a_oe,
  input wire logic drive_volt_pin_b_oe
);
  logic [7:0] mode_q;
  logic in_mem;
  logic mapped;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the mode register, kept from bus writes
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      mode_q <= 8'h00;
    else if (bus_wr && bus_addr == SLCD_ADDR_MODE)
      mode_q <= bus_wdata & SLCD_MODE_MASK;
  // Address decode mirrored from the register map
  assign in_mem = bus_addr >= SLCD_MEM_BASE && bus_addr <= SLCD_MEM_LAST;
  assign mapped = in_mem || bus_addr == SLCD_ADDR_PF7 ||
    bus_addr == SLCD_ADDR_PF8 || bus_addr == SLCD_ADDR_PF9 ||
    bus_addr == SLCD_ADDR_MODE || bus_addr == SLCD_ADDR_FRAME;
  a_off_outs_low: assert property (!mode_q[7] |=>
    seg_out[7:0] == 8'h00 && com_out == 3'h0) else $error("outputs not low");
  a_mode_read_back: assert property (bus_rd && bus_addr == SLCD_ADDR_MODE
    |=> bus_rdata == $past(mode_q)) else $error("mode read wrong");
  a_power_pins: assert property (drive_power_on == $past(mode_q[4]) &&
    drive_volt_pin_a_oe == drive_power_on &&
    drive_volt_pin_b_oe == drive_power_on) else $error("power pins wrong");
  a_frame_reserved: assert property (bus_rd && bus_addr == SLCD_ADDR_FRAME
    |=> bus_hit && bus_rdata[7:2] == 6'h00) else $error("frame bits set");
  a_dmem_upper: assert property (bus_rd && in_mem
    |=> bus_hit && bus_rdata[7:3] == 5'h00) else $error("memory high bits");
  a_unmapped_quiet: assert property (bus_rd && !mapped
    |=> !bus_hit && bus_rdata == 8'h00) else $error("unmapped answered");
  a_com_selected: assert property ((com_out & ~com_sel) == 3'h0)
    else $error("unselected common driven");
  a_static_all: assert property ((mode_q == 8'h84) [*2] |->
    com_sel == 3'h7) else $error("static commons differ");
  a_tri_one_com: assert property ((mode_q == 8'h91) [*2] |->
    $onehot(com_sel)) else $error("tri common not single");
  a_pullup_kept: assert property ($past(rst_n) |->
    pin_pullup_en == $past(port_pullup)) else $error("pullup not passed");
  c_tri: cover property (mode_q == 8'h91 && com_sel == 3'h4);
  c_static: cover property (mode_q == 8'h84 && com_out == 3'h7);
  c_unmapped: cover property (bus_rd && !mapped);
endmodule : slcd_scan_ctrl_props
bind slcd_scan_ctrl slcd_scan_ctrl_props u_props (.core_clk(core_clk),
  .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .bus_hit(bus_hit), .port_pullup(port_pullup), .seg_out(seg_out),
  .pin_pullup_en(pin_pullup_en), .com_out(com_out), .com_sel(com_sel),
  .drive_power_on(drive_power_on),
  .drive_volt_pin_a_oe(drive_volt_pin_a_oe),
  .drive_volt_pin_b_oe(drive_volt_pin_b_oe));

// ### bench/slcd_panel_model.sv
// Passive glass model: records which pixels see a drive difference
`timescale 1ns/10ps
module slcd_panel_model
  import slcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic [SLCD_NSEG-1:0] seg_out,
  input wire logic [SLCD_NCOM-1:0] com_out,
  input wire logic [SLCD_NCOM-1:0] com_sel,
  output logic [SLCD_NCOM-1:0][SLCD_NSEG-1:0] lit
);
  // A pixel is on when segment and common levels differ in its slot
  always_ff @(posedge core_clk)
    for (int c = 0; c < SLCD_NCOM; c++)
      if (com_sel[c])
        lit[c] <= seg_out ^ {SLCD_NSEG{com_out[c]}};
endmodule : slcd_panel_model

// ### bench/slcd_scan_ctrl_tb.sv
// Self-checking bench for the segment LCD scan controller
`timescale 1ns/10ps
module slcd_scan_ctrl_tb;
  import slcd_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] r; logic h;}
    slcd_row_s;
  logic core_clk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0, sub_clock_one = 0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00, bus_rdata, d;
  logic [21:0] port_dir_out = 22'h000000, port_latch = 22'h3FFFFF;
  logic [21:0] port_pullup = 22'h2AAAAA, pin_pullup_en;
  logic [29:0] seg_out, seg_oe;
  logic [2:0] com_out, com_sel;
  logic [2:0][29:0] lit;
  logic bus_hit, drive_power_on, pa_oe, pb_oe, panel_scan_clock, h;
  int n_errors = 0, n_compared = 0, n;
  slcd_row_s rows[9] = '{'{16'hFF57, 8'hFF, 8'hFF, 1}, '{16'hFF58, 8'hA5,
    8'hA5, 1}, '{16'hFF59, 8'hFF, 8'h3F, 1}, '{16'hFF91, 8'hFF, 8'h03, 1},
    '{16'hFF90, 8'h7F, 8'h17, 1}, '{16'hFA00, 8'hFF, 8'h07, 1},
    '{16'hFA1D, 8'h0A, 8'h02, 1}, '{16'hFA1E, 8'hFF, 8'h00, 0},
    '{16'hFF92, 8'hFF, 8'h00, 0}};
  logic [15:0] regs[5] = '{SLCD_ADDR_PF7, SLCD_ADDR_PF8, SLCD_ADDR_PF9,
    SLCD_ADDR_MODE, SLCD_ADDR_FRAME};
  always #20 core_clk = ~core_clk;
  // Sub clock kept fast so the longest frame stays short
  always #160 sub_clock_one = ~sub_clock_one;
  slcd_scan_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_hit(bus_hit),
    .sub_clock_one(sub_clock_one), .port_dir_out(port_dir_out),
    .port_latch(port_latch), .port_pullup(port_pullup), .seg_out(seg_out),
    .seg_oe(seg_oe), .pin_pullup_en(pin_pullup_en), .com_out(com_out),
    .com_sel(com_sel), .drive_power_on(drive_power_on),
    .drive_volt_pin_a_oe(pa_oe), .drive_volt_pin_b_oe(pb_oe),
    .panel_scan_clock(panel_scan_clock));
  slcd_panel_model u_panel (.core_clk(core_clk), .seg_out(seg_out),
    .com_out(com_out), .com_sel(com_sel), .lit(lit));
  task automatic cmp(string s, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", s, e, g);
    end
  endtask : cmp
  task automatic wr(logic [15:0] a, logic [7:0] w);
    @(negedge core_clk);
    bus_addr = a;
    bus_wdata = w;
    bus_wr = 1;
    @(negedge core_clk);
    bus_wr = 0;
  endtask : wr
  // Read data stands for one cycle after the strobe edge
  task automatic rd(logic [15:0] a);
    @(negedge core_clk);
    bus_addr = a;
    bus_rd = 1;
    @(negedge core_clk);
    bus_rd = 0;
    d = bus_rdata;
    h = bus_hit;
  endtask : rd
  // Cycles between two polarity flips, bounded
  task automatic measure();
    logic p;
    for (int k = 0; k < 2; k++)
    begin
      @(negedge core_clk);
      p = panel_scan_clock;
      n = 0;
      while (panel_scan_clock === p && n < 20000)
      begin
        @(negedge core_clk);
        n++;
      end
    end
  endtask : measure
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  initial
  begin
    // About twice the expected run of some 19,000 cycles
    #1600000;
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (6) @(negedge core_clk);
    rst_n = 1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      cmp("rdata", rows[i].r, d);
      cmp("hit", rows[i].h, h);
    end
    rst_n = 0;
    @(negedge core_clk);
    rst_n = 1;
    foreach (regs[i])
    begin
      rd(regs[i]);
      cmp("reset", 0, d);
    end
    cmp("power_off", 0, {drive_power_on, pa_oe, pb_oe});
    wr(SLCD_ADDR_PF7, 8'hFF);
    wr(SLCD_ADDR_MODE, 8'h10);
    repeat (2) @(negedge core_clk);
    cmp("seg_oe", 8'hFF, seg_oe[15:8]);
    cmp("seg_low", 0, seg_out[15:8]);
    cmp("power", 3'h7, {drive_power_on, pa_oe, pb_oe});
    cmp("com_low", 0, com_out);
    cmp("pullup", 22'h2AAAAA, pin_pullup_en);
    cmp("port_oe", 0, seg_oe[23:16]);
    cmp("port_lvl", 8'hFF, seg_out[23:16]);
    // Bring-up order: memory, pin function, power and mode, frame, enable
    wr(16'hFA00, 8'h05);
    wr(16'hFA1D, 8'h02);
    wr(SLCD_ADDR_PF9, 8'h3F);
    wr(SLCD_ADDR_MODE, 8'h11);
    wr(SLCD_ADDR_FRAME, 8'h00);
    // Supply settle time, scaled down along with the fast sub clock
    repeat (1024) @(negedge core_clk);
    cmp("settle_com", 0, com_out);
    wr(SLCD_ADDR_MODE, 8'h91);
    repeat (2000) @(negedge core_clk);
    for (int c = 0; c < 3; c++)
    begin
      cmp("lit_first", (8'h05 >> c) & 1, lit[c][0]);
      cmp("lit_last", (8'h02 >> c) & 1, lit[c][29]);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(SLCD_ADDR_MODE, 8'h00);
      wr(SLCD_ADDR_FRAME, s[7:0]);
      wr(SLCD_ADDR_MODE, 8'h84);
      measure();
      cmp("frame", 1, (n > (512 << s) - 9 && n < (512 << s) + 9));
    end
    cmp("static_lit", 3'h7, {lit[2][0], lit[1][0], lit[0][0]});
    rd(16'hFA1D);
    cmp("spare_bits", 8'h02, d);
    conclude();
  end
endmodule : slcd_scan_ctrl_tb
